// File: adcsq_pkg.sv
// constants, encodings and timing for the converter control block
// assumes a single 250 MHz system clock and no bus: all controls are pins
// Contract
// - a falling conversion start edge while chip select is low begins a conversion.
// - start requests are ignored until the running conversion has finished.
// - busy stays low for the whole conversion and rises when it completes.
// - chip select and read low keep outputs enabled; host latches on busy rise.
// - with only chip select low, outputs stay three-state unless read is low.
// - joined read/start shows previous result during busy, new one after.
// - a joined read/start falling edge while idle starts a conversion, shows previous result.
// - both mode selects low route address and configuration pins straight through.
// - address and configuration follow pins while write is low, hold when high.
// - scan mode ignores address pins but keeps differential, gain, polarity inputs.
// - single-ended scan converts all eight channels in turn, then repeats.
// - differential scan walks four adjacent pairs from channels zero and one.
// - any change of the lower mode select clears the scan counter.
// - scan counter steps one or two per conversion; address reported with result.
// - sequencer memory holds 16 entries of six config bits plus end flag.
// - program/readback access drives busy low and blocks conversions.
// - any change of either mode select resets the sequencer pointer to zero.
// - write strobe rising with read high stores an entry and advances pointer.
// - last written entry ends the sequence; wrap after 16 starts fresh sequence.
// - readback read low drives status word on address and top three data pins.
// - readback read high returns the data pins to high impedance.
// - each readback read advances pointer, wraps after 16; lowest bit marks end.
// - sequence run converts current entry, advances, wraps after the end entry.

package adcsq_pkg;

	// ***************************************************************
	// synchronised input bit positions
	// ***************************************************************
	localparam int SYNC_W = 12;
	localparam int IX_CONV = 0;
	localparam int IX_CS = 1;
	localparam int IX_RD = 2;
	localparam int IX_WR = 3;
	localparam int IX_MU = 4;
	localparam int IX_ML = 5;
	localparam int IX_DIFFERENTIAL_SELECT = 6;
	localparam int IX_GAIN = 7;
	localparam int IX_POL = 8;
	localparam int IX_ADDR = 9;

	// ***************************************************************
	// configuration entry layout {differential_select, addr[2:0], polarity, gain}
	// ***************************************************************
	localparam int CFG_W = 6;
	localparam int CF_GAIN = 0;
	localparam int CF_POL = 1;
	localparam int CF_ADDR = 2;
	localparam int CF_DIFFERENTIAL_SELECT = 5;
	localparam int ADDR_W = 3;
	localparam int STAT_W = 7;
	localparam int STAT_LOW_W = 3;
	localparam logic [CFG_W-1:0] CFG_RST = 6'h00;

	// ***************************************************************
	// sequencer memory
	// ***************************************************************
	localparam int SEQ_DEPTH = 16;
	localparam int PTR_W = 4;
	localparam logic [PTR_W-1:0] PTR_ZERO = 4'h0;
	localparam logic [PTR_W-1:0] PTR_STEP = 4'h1;
	localparam logic [ADDR_W-1:0] SCAN_ZERO = 3'h0;
	localparam logic [ADDR_W-1:0] SCAN_STEP_SE = 3'h1;
	localparam logic [ADDR_W-1:0] SCAN_STEP_DIFFERENTIAL_SELECT = 3'h2;

	// ***************************************************************
	// timing
	// ***************************************************************
	localparam int CLK_PERIOD_PS = 4000;
	localparam int CONV_TIME_NS = 1400;
	localparam int CONV_CYCLES = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RES_W = 12;

	// ***************************************************************
	// types
	// ***************************************************************
	typedef enum logic [1:0] {
		MODE_DIRECT = 2'h0,
		MODE_SCAN = 2'h1,
		MODE_PROG = 2'h2,
		MODE_RUN = 2'h3
	} adcsq_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_CONV = 2'h2
	} adcsq_state_t;

endpackage

// File: adcsq_edge_sync.sv
// two-stage synchroniser with edge detection, one lane per input bit
// assumes inputs may change at any time relative to the clock
`timescale 1ns/1ps
`default_nettype none

module adcsq_edge_sync #(
	parameter int W = 12
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_pin,
	output logic [W-1:0] o_level,
	output logic [W-1:0] o_fall,
	output logic [W-1:0] o_rise
);

	// ***************************************************************
	// per-bit lanes
	// ***************************************************************
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_lane
			logic meta_q;
			logic sync_q;
			logic last_q;
			// idle-high reset keeps strobes from firing at release for inputs held high; an input held low gives a fall strobe
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					meta_q <= 1'b1;
					sync_q <= 1'b1;
					last_q <= 1'b1;
				end else begin
					meta_q <= i_pin[g];
					sync_q <= meta_q;
					last_q <= sync_q;
				end
			end
			// edges use only the second stage and its delayed copy
			assign o_level[g] = sync_q;
			assign o_fall[g] = last_q & ~sync_q;
			assign o_rise[g] = ~last_q & sync_q;
		end
	endgenerate

endmodule

`default_nettype wire

// File: adcsq_seq_mem.sv
// sequencer memory: configuration array plus one end-of-sequence flag per entry
// assumes one write per cycle at the pointer it is given
`timescale 1ns/1ps
`default_nettype none

module adcsq_seq_mem #(
	parameter int DEPTH = adcsq_pkg::SEQ_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_we,
	input wire logic [adcsq_pkg::PTR_W-1:0] i_ptr,
	input wire logic [adcsq_pkg::CFG_W-1:0] i_cfg,
	output logic [adcsq_pkg::CFG_W-1:0] o_cfg,
	output logic o_end
);

	// ***************************************************************
	// storage
	// ***************************************************************
	logic [adcsq_pkg::CFG_W-1:0] cfg_mem [DEPTH];
	logic [DEPTH-1:0] end_q;
	logic [DEPTH-1:0] end_d;

	// the newest write is the only end; this also discards older entries after a wrap
	assign end_d = {{(DEPTH-1){1'b0}}, 1'b1} << i_ptr;

	// array has no reset: contents only matter once programmed
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			cfg_mem[i_ptr] <= i_cfg;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			end_q <= '0;
		end else if (i_we) begin
			end_q <= end_d;
		end
	end

	assign o_cfg = cfg_mem[i_ptr];
	assign o_end = end_q[i_ptr];

endmodule

`default_nettype wire

// File: adcsq_top.sv
// converter control: start/busy handshake, output enables, direct, scan and sequencer modes
// assumes the converter core result is valid on I_CORE_RESULT when the count ends
`timescale 1ns/1ps
`default_nettype none

module adcsq_top #(
	parameter int RES_W = adcsq_pkg::RES_W,
	parameter int CONV_CYCLES = adcsq_pkg::CONV_CYCLES
) (
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	input wire logic I_CONVERSION_START_N,
	input wire logic I_CS_N,
	input wire logic I_RD_N,
	input wire logic I_WR_N,
	input wire logic I_MODE_SELECT_UPPER,
	input wire logic I_MODE_SELECT_LOWER,
	input wire logic I_DIFFERENTIAL_SELECT,
	input wire logic I_GAIN_RANGE_SELECT,
	input wire logic I_POLARITY_SELECT,
	input wire logic [adcsq_pkg::ADDR_W-1:0] I_MUX_ADDRESS_IN,
	input wire logic [RES_W-1:0] I_CORE_RESULT,
	output logic O_BUSY_N,
	output logic O_CORE_START,
	output logic [adcsq_pkg::ADDR_W-1:0] O_MUX_SELECT,
	output logic O_MUX_DIFFERENTIAL,
	output logic O_MUX_GAIN,
	output logic O_MUX_POLARITY,
	output logic [RES_W-1:0] O_DATA_OUT,
	output logic [RES_W-1:0] O_DATA_OE_N,
	output logic [adcsq_pkg::ADDR_W-1:0] O_MUX_ADDRESS_OUT,
	output logic O_DIFFERENTIAL_FLAG_OUT,
	output logic O_ADDRESS_OE_N
);

	// ***************************************************************
	// input synchronisation
	// ***************************************************************
	logic [adcsq_pkg::SYNC_W-1:0] pin_raw;
	logic [adcsq_pkg::SYNC_W-1:0] lvl;
	logic [adcsq_pkg::SYNC_W-1:0] fall;
	logic [adcsq_pkg::SYNC_W-1:0] rise;

	assign pin_raw = {I_MUX_ADDRESS_IN, I_POLARITY_SELECT, I_GAIN_RANGE_SELECT,
		I_DIFFERENTIAL_SELECT, I_MODE_SELECT_LOWER, I_MODE_SELECT_UPPER,
		I_WR_N, I_RD_N, I_CS_N, I_CONVERSION_START_N};

	adcsq_edge_sync #(
		.W(adcsq_pkg::SYNC_W)
	) u_sync (
		.i_clk(I_CLK_SYS),
		.i_rst_n(I_RST_N),
		.i_pin(pin_raw),
		.o_level(lvl),
		.o_fall(fall),
		.o_rise(rise)
	);

	// ***************************************************************
	// decoded pins and mode
	// ***************************************************************
	wire cs_act = ~lvl[adcsq_pkg::IX_CS];
	wire rd_act = ~lvl[adcsq_pkg::IX_RD];
	wire wr_act = ~lvl[adcsq_pkg::IX_WR];
	adcsq_pkg::adcsq_mode_t mode;
	assign mode = adcsq_pkg::adcsq_mode_t'({lvl[adcsq_pkg::IX_MU], lvl[adcsq_pkg::IX_ML]});
	wire lower_chg = rise[adcsq_pkg::IX_ML] | fall[adcsq_pkg::IX_ML];
	wire mode_chg = lower_chg | rise[adcsq_pkg::IX_MU] | fall[adcsq_pkg::IX_MU];
	wire in_direct = (mode == adcsq_pkg::MODE_DIRECT);
	wire in_scan = (mode == adcsq_pkg::MODE_SCAN);
	wire in_prog = (mode == adcsq_pkg::MODE_PROG);
	wire in_run = (mode == adcsq_pkg::MODE_RUN);

	// configuration pins gathered as one entry
	logic [adcsq_pkg::CFG_W-1:0] pin_cfg;
	assign pin_cfg = lvl[adcsq_pkg::SYNC_W-1:adcsq_pkg::IX_DIFFERENTIAL_SELECT] == '0 ? '0 :
		{lvl[adcsq_pkg::IX_DIFFERENTIAL_SELECT], lvl[adcsq_pkg::IX_ADDR +: adcsq_pkg::ADDR_W],
		lvl[adcsq_pkg::IX_POL], lvl[adcsq_pkg::IX_GAIN]};

	// ***************************************************************
	// write-strobe latch of address and configuration
	// ***************************************************************
	logic [adcsq_pkg::CFG_W-1:0] cfg_q;
	logic [adcsq_pkg::CFG_W-1:0] live_cfg;

	// transparent while write is low, frozen from its rising edge on
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cfg_q <= adcsq_pkg::CFG_RST;
		end else if (wr_act) begin
			cfg_q <= pin_cfg;
		end
	end
	assign live_cfg = wr_act ? pin_cfg : cfg_q;

	// ***************************************************************
	// conversion state machine
	// ***************************************************************
	adcsq_pkg::adcsq_state_t state_q;
	adcsq_pkg::adcsq_state_t state_d;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	localparam logic [15:0] CNT_LAST = 16'(CONV_CYCLES - 1);

	wire converting = (state_q == adcsq_pkg::ST_CONV);
	// a start is only seen while idle, so repeats during a conversion are dropped
	wire start_ok = fall[adcsq_pkg::IX_CONV] & cs_act & ~converting & ~in_prog;
	wire conv_done = converting & (cnt_q == CNT_LAST);

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		unique case (state_q)
			adcsq_pkg::ST_IDLE: begin
				if (start_ok) begin
					state_d = adcsq_pkg::ST_CONV;
					cnt_d = '0;
				end
			end
			adcsq_pkg::ST_CONV: begin
				if (conv_done) begin
					state_d = adcsq_pkg::ST_IDLE;
				end else begin
					cnt_d = cnt_q + 16'h0001;
				end
			end
			default: begin
				state_d = adcsq_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_q <= adcsq_pkg::ST_IDLE;
			cnt_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// ***************************************************************
	// sequencer pointer and memory
	// ***************************************************************
	logic [adcsq_pkg::PTR_W-1:0] ptr_q;
	logic [adcsq_pkg::CFG_W-1:0] mem_cfg;
	logic mem_end;
	logic run_end_q;
	logic conv_scan_q;
	logic conv_run_q;
	logic [adcsq_pkg::CFG_W-1:0] mux_q;

	wire prog_wr = in_prog & rise[adcsq_pkg::IX_WR] & ~rd_act;
	wire rb_step = in_prog & ~wr_act & rise[adcsq_pkg::IX_RD];
	wire run_step = conv_done & conv_run_q;

	adcsq_seq_mem #(
		.DEPTH(adcsq_pkg::SEQ_DEPTH)
	) u_mem (
		.i_clk(I_CLK_SYS),
		.i_rst_n(I_RST_N),
		.i_we(prog_wr),
		.i_ptr(ptr_q),
		.i_cfg(pin_cfg),
		.o_cfg(mem_cfg),
		.o_end(mem_end)
	);

	// mode change wins: pointer is always known to restart at zero
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ptr_q <= adcsq_pkg::PTR_ZERO;
		end else if (mode_chg) begin
			ptr_q <= adcsq_pkg::PTR_ZERO;
		end else if (prog_wr || rb_step) begin
			ptr_q <= ptr_q + adcsq_pkg::PTR_STEP;
		end else if (run_step) begin
			ptr_q <= run_end_q ? adcsq_pkg::PTR_ZERO : ptr_q + adcsq_pkg::PTR_STEP;
		end
	end

	// ***************************************************************
	// scan counter
	// ***************************************************************
	logic [adcsq_pkg::ADDR_W-1:0] scan_q;

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			scan_q <= adcsq_pkg::SCAN_ZERO;
		end else if (lower_chg) begin
			scan_q <= adcsq_pkg::SCAN_ZERO;
		end else if (conv_done && conv_scan_q) begin
			// pairs step by two so the counter stays on the even channel
			scan_q <= scan_q + (mux_q[adcsq_pkg::CF_DIFFERENTIAL_SELECT] ?
				adcsq_pkg::SCAN_STEP_DIFFERENTIAL_SELECT : adcsq_pkg::SCAN_STEP_SE);
		end
	end

	// ***************************************************************
	// multiplexer selection
	// ***************************************************************
	logic [adcsq_pkg::CFG_W-1:0] sel_cfg;
	logic [adcsq_pkg::CFG_W-1:0] scan_cfg;

	// scan keeps differential_select, gain and polarity from the pins, address from the counter
	assign scan_cfg = {live_cfg[adcsq_pkg::CF_DIFFERENTIAL_SELECT], scan_q,
		live_cfg[adcsq_pkg::CF_POL], live_cfg[adcsq_pkg::CF_GAIN]};
	assign sel_cfg = in_scan ? scan_cfg : (in_run ? mem_cfg : live_cfg);

	// selection tracks while idle and is frozen for the whole conversion
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			mux_q <= adcsq_pkg::CFG_RST;
			conv_scan_q <= 1'b0;
			conv_run_q <= 1'b0;
			run_end_q <= 1'b0;
		end else if (!converting) begin
			mux_q <= sel_cfg;
			conv_scan_q <= in_scan;
			conv_run_q <= in_run;
			run_end_q <= mem_end;
		end
	end

	assign O_MUX_SELECT = mux_q[adcsq_pkg::CF_ADDR +: adcsq_pkg::ADDR_W];
	assign O_MUX_DIFFERENTIAL = mux_q[adcsq_pkg::CF_DIFFERENTIAL_SELECT];
	assign O_MUX_GAIN = mux_q[adcsq_pkg::CF_GAIN];
	assign O_MUX_POLARITY = mux_q[adcsq_pkg::CF_POL];

	// ***************************************************************
	// result and reported address
	// ***************************************************************
	logic [RES_W-1:0] result_q;
	logic [adcsq_pkg::ADDR_W-1:0] res_addr_q;
	logic res_differential_select_q;

	// old result stays visible until the conversion ends
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			result_q <= '0;
			res_addr_q <= adcsq_pkg::SCAN_ZERO;
			res_differential_select_q <= 1'b0;
		end else if (conv_done) begin
			result_q <= I_CORE_RESULT;
			res_addr_q <= mux_q[adcsq_pkg::CF_ADDR +: adcsq_pkg::ADDR_W];
			res_differential_select_q <= mux_q[adcsq_pkg::CF_DIFFERENTIAL_SELECT];
		end
	end

	// ***************************************************************
	// output pins and enables
	// ***************************************************************
	logic [adcsq_pkg::STAT_W-1:0] status;
	logic [RES_W-1:0] data_d;
	logic [RES_W-1:0] data_oe_n_d;
	logic [adcsq_pkg::ADDR_W-1:0] aout_d;
	logic dflag_d;
	logic aoe_n_d;

	// bypass so the new result meets the pins at the edge that raises busy
	wire [RES_W-1:0] res_now = conv_done ? I_CORE_RESULT : result_q;
	wire [adcsq_pkg::ADDR_W-1:0] addr_now = conv_done ?
		mux_q[adcsq_pkg::CF_ADDR +: adcsq_pkg::ADDR_W] : res_addr_q;
	wire differential_select_now = conv_done ? mux_q[adcsq_pkg::CF_DIFFERENTIAL_SELECT] : res_differential_select_q;

	// status word: {differential_select, addr, polarity, gain, end flag}
	assign status = {mem_cfg, mem_end};
	wire rb_read = in_prog & ~wr_act & cs_act & rd_act;
	wire norm_read = ~in_prog & cs_act & rd_act;

	always_comb begin
		data_d = res_now;
		data_oe_n_d = {RES_W{1'b1}};
		aout_d = addr_now;
		dflag_d = differential_select_now;
		aoe_n_d = 1'b1;
		if (rb_read) begin
			// only the top data bits carry status; the rest stay released
			data_d = '0;
			data_d[RES_W-1 -: adcsq_pkg::STAT_LOW_W] = status[adcsq_pkg::STAT_LOW_W-1:0];
			data_oe_n_d[RES_W-1 -: adcsq_pkg::STAT_LOW_W] = '0;
			aout_d = status[adcsq_pkg::STAT_W-2 -: adcsq_pkg::ADDR_W];
			dflag_d = status[adcsq_pkg::STAT_W-1];
			aoe_n_d = 1'b0;
		end else if (norm_read) begin
			data_oe_n_d = '0;
			aoe_n_d = 1'b0;
		end
	end

	// registered pins: one cycle behind the synchronised strobes
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_DATA_OUT <= '0;
			O_DATA_OE_N <= '1;
			O_MUX_ADDRESS_OUT <= adcsq_pkg::SCAN_ZERO;
			O_DIFFERENTIAL_FLAG_OUT <= 1'b0;
			O_ADDRESS_OE_N <= 1'b1;
		end else begin
			O_DATA_OUT <= data_d;
			O_DATA_OE_N <= data_oe_n_d;
			O_MUX_ADDRESS_OUT <= aout_d;
			O_DIFFERENTIAL_FLAG_OUT <= dflag_d;
			O_ADDRESS_OE_N <= aoe_n_d;
		end
	end

	// ***************************************************************
	// busy and core start
	// ***************************************************************
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_BUSY_N <= 1'b1;
			O_CORE_START <= 1'b0;
		end else begin
			O_BUSY_N <= ~(state_d == adcsq_pkg::ST_CONV) & ~in_prog;
			O_CORE_START <= start_ok;
		end
	end

endmodule

`default_nettype wire

// File: adcsq_chk.sv
// assertions on the converter control pins
// assumes bind onto adcsq_top; pin changes are seen within six cycles
`timescale 1ns/1ps
`default_nettype none

module adcsq_chk #(
	parameter int RES_W = 12,
	parameter int CONV_CYCLES = 350
) (
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	input wire logic I_CS_N,
	input wire logic I_RD_N,
	input wire logic I_WR_N,
	input wire logic I_MODE_SELECT_UPPER,
	input wire logic I_MODE_SELECT_LOWER,
	input wire logic I_DIFFERENTIAL_SELECT,
	input wire logic I_GAIN_RANGE_SELECT,
	input wire logic I_POLARITY_SELECT,
	input wire logic [adcsq_pkg::ADDR_W-1:0] I_MUX_ADDRESS_IN,
	input wire logic O_BUSY_N,
	input wire logic O_CORE_START,
	input wire logic [adcsq_pkg::ADDR_W-1:0] O_MUX_SELECT,
	input wire logic O_MUX_DIFFERENTIAL,
	input wire logic O_MUX_GAIN,
	input wire logic O_MUX_POLARITY,
	input wire logic [RES_W-1:0] O_DATA_OE_N,
	input wire logic O_ADDRESS_OE_N
);
	localparam int BUSY_MIN = CONV_CYCLES - 1;
	localparam int BUSY_MAX = CONV_CYCLES + 1;
	localparam logic [RES_W-1:0] RB_OE = {3'h0, {(RES_W-3){1'b1}}};
	logic prog;
	logic direct;
	logic [5:0] pins;
	// ****************************************
	// raw mode decode; the repetitions absorb the synchroniser delay
	// ****************************************
	assign prog = I_MODE_SELECT_UPPER & ~I_MODE_SELECT_LOWER;
	assign direct = ~I_MODE_SELECT_UPPER & ~I_MODE_SELECT_LOWER;
	assign pins = {I_DIFFERENTIAL_SELECT, I_MUX_ADDRESS_IN, I_POLARITY_SELECT, I_GAIN_RANGE_SELECT};
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);

	a_start_busy: assert property (O_CORE_START |-> !O_BUSY_N)
		else $error("busy not low at core start");
	a_busy_span: assert property (O_CORE_START |-> ##[BUSY_MIN:BUSY_MAX] $rose(O_BUSY_N))
		else $error("busy did not rise after the conversion time");
	a_no_restart: assert property (O_CORE_START |-> $past(O_BUSY_N) ##1 !O_CORE_START)
		else $error("start accepted during a conversion");
	a_rd_idle: assert property (I_RD_N [*6] |-> (&O_DATA_OE_N) && O_ADDRESS_OE_N)
		else $error("outputs driven with read high");
	a_rd_drive: assert property ((!I_CS_N && !I_RD_N && !prog) [*6] |->
		O_DATA_OE_N == '0 && !O_ADDRESS_OE_N)
		else $error("outputs not driven with select and read low");
	a_readback_oe: assert property ((prog && I_WR_N && !I_RD_N && !I_CS_N) [*6] |->
		O_DATA_OE_N == RB_OE && !O_ADDRESS_OE_N)
		else $error("wrong enables during readback");
	a_prog_busy: assert property (prog [*6] |-> !O_BUSY_N)
		else $error("busy high in program mode");
	a_direct_mux: assert property ((direct && !I_WR_N && O_BUSY_N && $stable(pins)) [*6] |->
		{O_MUX_DIFFERENTIAL, O_MUX_SELECT, O_MUX_POLARITY, O_MUX_GAIN} == pins)
		else $error("mux does not follow the pins");
endmodule

bind adcsq_top adcsq_chk #(.RES_W(RES_W), .CONV_CYCLES(CONV_CYCLES)) u_adcsq_chk (
	.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_CS_N(I_CS_N), .I_RD_N(I_RD_N),
	.I_WR_N(I_WR_N), .I_MODE_SELECT_UPPER(I_MODE_SELECT_UPPER),
	.I_MODE_SELECT_LOWER(I_MODE_SELECT_LOWER), .I_DIFFERENTIAL_SELECT(I_DIFFERENTIAL_SELECT),
	.I_GAIN_RANGE_SELECT(I_GAIN_RANGE_SELECT), .I_POLARITY_SELECT(I_POLARITY_SELECT),
	.I_MUX_ADDRESS_IN(I_MUX_ADDRESS_IN), .O_BUSY_N(O_BUSY_N), .O_CORE_START(O_CORE_START),
	.O_MUX_SELECT(O_MUX_SELECT), .O_MUX_DIFFERENTIAL(O_MUX_DIFFERENTIAL),
	.O_MUX_GAIN(O_MUX_GAIN), .O_MUX_POLARITY(O_MUX_POLARITY),
	.O_DATA_OE_N(O_DATA_OE_N), .O_ADDRESS_OE_N(O_ADDRESS_OE_N)
);
`default_nettype wire

// File: adcsq_core_model.sv
// behavioural converter core behind the control block
// assumes a one-cycle start pulse; result valid only while converting
`timescale 1ns/1ps
`default_nettype none

module adcsq_core_model #(
	parameter int CONV_CYCLES = 10
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	output logic [11:0] o_result
);
	logic [11:0] val_q;
	logic [15:0] left_q;
	// outside a conversion the value is inverted so a stale sample fails
	assign o_result = (left_q != 16'h0) ? val_q : ~val_q;
	// each start steps the result by a fixed amount
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			val_q <= 12'hA5A;
			left_q <= 16'h0;
		end else if (i_start) begin
			val_q <= val_q + 12'h111;
			left_q <= 16'(CONV_CYCLES + 2);
		end else if (left_q != 16'h0) begin
			left_q <= left_q - 16'h1;
		end
	end
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the converter control block
// assumes the core model on the result port and a short conversion count
`timescale 1ns/1ps
`default_nettype none

module testbench;
	localparam int CONV = 10;
	logic clk, rst_n, cv, cs, rd, wr, mu, ml, dif, gn, pl;
	logic [2:0] ad, msel, aout;
	logic [11:0] res, dout, doe_n;
	logic busy_n, core_start, mdif, mgain, mpol, dflag, aoe_n;
	int fails, comparisons, nconv;

	adcsq_top #(.RES_W(12), .CONV_CYCLES(CONV)) u_adcsq_top (
		.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CONVERSION_START_N(cv), .I_CS_N(cs),
		.I_RD_N(rd), .I_WR_N(wr), .I_MODE_SELECT_UPPER(mu), .I_MODE_SELECT_LOWER(ml),
		.I_DIFFERENTIAL_SELECT(dif), .I_GAIN_RANGE_SELECT(gn), .I_POLARITY_SELECT(pl),
		.I_MUX_ADDRESS_IN(ad), .I_CORE_RESULT(res), .O_BUSY_N(busy_n),
		.O_CORE_START(core_start), .O_MUX_SELECT(msel), .O_MUX_DIFFERENTIAL(mdif),
		.O_MUX_GAIN(mgain), .O_MUX_POLARITY(mpol), .O_DATA_OUT(dout), .O_DATA_OE_N(doe_n),
		.O_MUX_ADDRESS_OUT(aout), .O_DIFFERENTIAL_FLAG_OUT(dflag), .O_ADDRESS_OE_N(aoe_n)
	);
	adcsq_core_model #(.CONV_CYCLES(CONV)) u_adcsq_core_model (
		.i_clk(clk), .i_rst_n(rst_n), .i_start(core_start), .o_result(res)
	);

	// ****************************************
	// clock and shared tasks
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// bounded wait on busy, sampled mid-cycle so edge updates have landed
	task automatic wt(input logic v);
		int k;
		k = 0;
		while (busy_n !== v && k < 100) begin
			@(negedge clk);
			k++;
		end
		chk(k < 100, 1'b1);
	endtask

	function automatic logic [11:0] rv(input int n);
		rv = 12'hA5A + 12'h111 * n[11:0];
	endfunction

	// one conversion; j joins read to start as a slow-memory host does
	task automatic conv(input bit j);
		@(posedge clk);
		cv <= 1'b0;
		if (j) rd <= 1'b0;
		wt(1'b0);
		if (j) chk(dout, rv(nconv));
		@(posedge clk);
		if (!j) cv <= 1'b1;
		wt(1'b1);
		chk(dout, rv(nconv + 1));
		nconv++;
		@(posedge clk);
		cv <= 1'b1;
		if (j) rd <= 1'b1;
		cyc(5);
	endtask

	task automatic cva(input logic [3:0] e);
		conv(1'b0);
		@(negedge clk);
		chk({dflag, aout}, e);
	endtask

	task automatic wrt(input logic [5:0] c);
		@(posedge clk);
		{dif, ad, pl, gn} <= c;
		wr <= 1'b0;
		cyc(4);
		wr <= 1'b1;
		cyc(5);
	endtask

	task automatic rbk(input logic [6:0] e, input bit full);
		@(posedge clk);
		rd <= 1'b0;
		cyc(5);
		@(negedge clk);
		if (full) chk({dflag, aout, dout[11:9]}, e);
		else chk(dout[9], e[0]);
		chk(doe_n, 12'h1FF);
		@(posedge clk);
		rd <= 1'b1;
		cyc(5);
		@(negedge clk);
		chk(doe_n, 12'hFFF);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_direct();
		@(posedge clk);
		{dif, ad, pl, gn} <= 6'h35;
		wr <= 1'b0;
		cyc(8);
		@(negedge clk);
		chk({mdif, msel, mpol, mgain}, 6'h35);
		@(posedge clk);
		wr <= 1'b1;
		cyc(2);
		{dif, ad} <= 4'h2;
		cyc(8);
		@(negedge clk);
		chk({mdif, msel, mpol, mgain}, 6'h35);
		@(posedge clk);
		{dif, ad} <= 4'hD;
		cva(4'hD);
		@(posedge clk);
		wr <= 1'b0;
		$display("direct done");
	endtask

	task automatic t_restart();
		@(posedge clk);
		cv <= 1'b0;
		wt(1'b0);
		@(posedge clk);
		cv <= 1'b1;
		cyc(1);
		cv <= 1'b0;
		cyc(1);
		cv <= 1'b1;
		wt(1'b1);
		chk(dout, rv(nconv + 1));
		nconv++;
		cyc(15);
		@(negedge clk);
		chk(busy_n, 1'b1);
		$display("restart done");
	endtask

	task automatic t_select();
		@(posedge clk);
		cs <= 1'b1;
		cv <= 1'b0;
		cyc(3);
		cv <= 1'b1;
		cyc(6);
		cs <= 1'b0;
		cyc(12);
		@(negedge clk);
		chk(busy_n, 1'b1);
		@(posedge clk);
		rd <= 1'b1;
		cyc(8);
		@(negedge clk);
		chk({aoe_n, doe_n}, 13'h1FFF);
		@(posedge clk);
		rd <= 1'b0;
		cyc(8);
		@(negedge clk);
		chk({aoe_n, doe_n}, 13'h0000);
		$display("select done");
	endtask

	task automatic t_slow();
		@(posedge clk);
		rd <= 1'b1;
		cyc(6);
		conv(1'b1);
		conv(1'b1);
		@(posedge clk);
		rd <= 1'b0;
		$display("joined strobe done");
	endtask

	task automatic t_scan();
		@(posedge clk);
		ml <= 1'b1;
		ad <= 3'h7;
		dif <= 1'b0;
		cyc(6);
		for (int i = 0; i < 9; i++) cva({1'b0, 3'(i)});
		@(posedge clk);
		ml <= 1'b0;
		cyc(8);
		dif <= 1'b1;
		ml <= 1'b1;
		cyc(6);
		for (int i = 0; i < 5; i++) cva({1'b1, 3'(2 * i)});
		$display("scan done");
	endtask

	task automatic t_prog();
		@(posedge clk);
		rd <= 1'b1;
		wr <= 1'b1;
		cyc(4);
		{mu, ml} <= 2'b10;
		cyc(8);
		@(negedge clk);
		chk(busy_n, 1'b0);
		for (int i = 0; i < 16; i++) wrt(6'(i));
		wrt(6'h2B);
		wrt(6'h14);
		@(posedge clk);
		ml <= 1'b1;
		cyc(6);
		ml <= 1'b0;
		cyc(6);
		for (int i = 0; i < 17; i++) rbk({(i % 16 == 0) ? 6'h2B : 6'h14, i % 16 == 1}, i % 16 < 2);
		$display("program done");
	endtask

	task automatic t_run();
		@(posedge clk);
		ml <= 1'b1;
		cyc(4);
		rd <= 1'b0;
		cyc(6);
		cva(4'hA);
		cva(4'h5);
		cva(4'hA);
		$display("run done");
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// hang guard, well beyond the roughly one thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		close_out();
	end

	initial begin
		{cv, cs, rd, wr, mu, ml, dif, gn, pl} = 9'b100100000;
		ad = 3'h0;
		rst_n = 1'b0;
		cyc(5);
		rst_n <= 1'b1;
		cyc(3);
		t_direct();
		t_restart();
		t_select();
		t_slow();
		t_scan();
		t_prog();
		t_run();
		close_out();
	end
endmodule
`default_nettype wire
